// ==== design/gcc_regs_defs.svh ====
`ifndef GCC_REGS_DEFS_SVH
`define GCC_REGS_DEFS_SVH

//----------------------------------------------------------------------
// Function
//----------------------------------------------------------------------
// Function
// - Global reset bit resets both datapaths and all management registers.
// - Global reset bit clears itself on the next clock cycle.
// - Broadcast bit low: channel writes hit only the addressed channel.
// - Broadcast bit high: channel writes update both channels alike.
// - Pass pin shows selected side's result only while verification enabled.
// - Select 0000 routes first channel high-speed status; 0001 reserved.
// - Selects 0100 to 0111 route first channel low-speed lanes 0 to 3.
// - Select 1000 routes second channel high-speed status; 1001 reserved.
// - Power-off bit stops the channel datapath; management stays alive.
// - Receive mode bit high forces 1:1, else ratio select decides.
// - Transmit mode bit high forces 1:1, else ratio select decides.
// - Hysteresis 00 uses the standard Ethernet loss-of-sync behaviour.
// - Hysteresis 01: one code or disparity error drops sync at once.
// - Hysteresis 10: two adjacent errors drop sync at once.
// - Hysteresis 11: three adjacent errors drop sync at once.
// - Receive ratio select: 0 gives 1:2, 1 gives 1:4, reset 1:4.
// - Transmit ratio select: 0 gives 2:1, 1 gives 4:1, reset 4:1.
// - Self-clearing bits pulse one cycle on a one and read as zero.

//----------------------------------------------------------------------
// Register map
//----------------------------------------------------------------------
`define GCC_GLOBAL_ADDR   5'h00
`define GCC_CHAN_ADDR     5'h01
`define GCC_GLOBAL_RST    16'h0600
`define GCC_CHAN_RST      16'h0300
`define GCC_G_RESET_BIT   15
`define GCC_G_BCAST_BIT   11
`define GCC_G_RSV_HI      10
`define GCC_G_RSV_LO      8
`define GCC_G_RSV7_BIT    7
`define GCC_G_SEL_HI      3
`define GCC_C_PWR_BIT     15
`define GCC_C_RXMODE_BIT  13
`define GCC_C_TXMODE_BIT  12
`define GCC_C_HYST_HI     11
`define GCC_C_HYST_LO     10
`define GCC_C_RXSEL_BIT   9
`define GCC_C_TXSEL_BIT   8

//----------------------------------------------------------------------
// Pass select code layout
//----------------------------------------------------------------------
`define GCC_SEL_CH_BIT    3
`define GCC_SEL_LS_BIT    2
`define GCC_SEL_HS_LANE   2'h0

//----------------------------------------------------------------------
// Management frame
//----------------------------------------------------------------------
`define GCC_PRE_LEN       6'h20
`define GCC_HDR_LAST      6'h0C
`define GCC_DATA_LAST     6'h0F
`define GCC_TA_LAST       6'h01
`define GCC_OP_RD         2'h2
`define GCC_OP_WR         2'h1

//----------------------------------------------------------------------
// Synchronisation thresholds
//----------------------------------------------------------------------
`define GCC_ACQ_COMMAS    2'h3
`define GCC_STD_BAD_LIM   3'h4
`define GCC_STD_GOOD_RUN  2'h3

`endif

// ==== design/gcc_pkg.sv ====
package gcc_pkg;

    // Management frame phases
    typedef enum logic [1:0] {
        GCC_MD_PRE  = 2'b00,
        GCC_MD_HDR  = 2'b01,
        GCC_MD_TA   = 2'b10,
        GCC_MD_DATA = 2'b11
    } gcc_md_state_t;

    // Lane ratio of one direction
    typedef enum logic [1:0] {
        GCC_RATIO_1 = 2'b00,
        GCC_RATIO_2 = 2'b01,
        GCC_RATIO_4 = 2'b10
    } gcc_ratio_t;

    // Loss-of-sync hysteresis settings
    typedef enum logic [1:0] {
        GCC_HYST_STD = 2'b00,
        GCC_HYST_ONE = 2'b01,
        GCC_HYST_TWO = 2'b10,
        GCC_HYST_THR = 2'b11
    } gcc_hyst_t;

endpackage

// ==== design/gcc_sync_fsm.sv ====
`timescale 1ns/10ps
`include "gcc_regs_defs.svh"

module gcc_sync_fsm (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              hold,
    // Hysteresis setting
    input  wire gcc_pkg::gcc_hyst_t hyst,
    // Decoded symbol stream
    input  wire logic              sym_valid,
    input  wire logic              sym_err,
    input  wire logic              sym_comma,
    // Status
    output logic                   in_sync_q
);

    logic [1:0] acq_q;
    logic [2:0] bad_q;
    logic [1:0] good_q;
    logic [2:0] lim;

    //------------------------------------------------------------------
    // Error limit per setting
    //------------------------------------------------------------------
    // Adjacent-error limit; standard mode counts with decay
    always_comb begin
        unique case (hyst)
            gcc_pkg::GCC_HYST_STD: lim = `GCC_STD_BAD_LIM;
            gcc_pkg::GCC_HYST_ONE: lim = 3'h1;
            gcc_pkg::GCC_HYST_TWO: lim = 3'h2;
            gcc_pkg::GCC_HYST_THR: lim = 3'h3;
        endcase
    end

    //------------------------------------------------------------------
    // Sync state machine
    //------------------------------------------------------------------
    // Held idle while the channel is powered off
    always_ff @(posedge sys_clk) begin
        if (rst || hold) begin
            in_sync_q <= 1'b0;
            acq_q     <= 2'h0;
            bad_q     <= 3'h0;
            good_q    <= 2'h0;
        end else if (sym_valid) begin
            if (!in_sync_q) begin
                bad_q  <= 3'h0;
                good_q <= 2'h0;
                if (sym_err)
                    acq_q <= 2'h0;
                else if (sym_comma) begin
                    if (acq_q == `GCC_ACQ_COMMAS - 2'h1) begin
                        in_sync_q <= 1'b1;
                        acq_q     <= 2'h0;
                    end else
                        acq_q <= acq_q + 2'h1;
                end
            end else if (sym_err) begin
                good_q <= 2'h0;
                if (bad_q + 3'h1 >= lim) begin
                    in_sync_q <= 1'b0;
                    bad_q     <= 3'h0;
                end else
                    bad_q <= bad_q + 3'h1;
            end else if (hyst != gcc_pkg::GCC_HYST_STD) begin
                bad_q <= 3'h0;
            end else if (bad_q != 3'h0) begin
                // Standard decay: a run of good codes forgives one error
                if (good_q == `GCC_STD_GOOD_RUN) begin
                    bad_q  <= bad_q - 3'h1;
                    good_q <= 2'h0;
                end else
                    good_q <= good_q + 2'h1;
            end
        end
    end

endmodule

// ==== design/gcc_regs.sv ====
`timescale 1ns/10ps
`include "gcc_regs_defs.svh"

module gcc_regs (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Management port
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe,
    input  wire logic [3:0] port_addr_hi,
    // Pattern verification status
    input  wire logic [1:0] hs_verify_en,
    input  wire logic [1:0] ls_verify_en,
    input  wire logic [1:0] hs_verify_ok,
    input  wire logic [7:0] ls_verify_ok,
    output logic            pattern_pass_pin,
    // Symbol streams per channel
    input  wire logic [1:0] sym_valid,
    input  wire logic [1:0] sym_err,
    input  wire logic [1:0] sym_comma,
    output logic [1:0]      chan_in_sync,
    // Datapath control
    output logic            datapath_reset,
    output logic [1:0]      channel_power_off,
    output logic [3:0]      rx_ratio,
    output logic [3:0]      tx_ratio
);

    //------------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------------
    gcc_pkg::gcc_md_state_t md_q;
    logic [5:0]  cnt_q;
    logic [15:0] sh_q;
    logic [15:0] rd_q;
    logic [1:0]  op_q;
    logic        pa0_q;
    logic [4:0]  ra_q;
    logic        hit_q;
    logic        mdc_q;
    logic        rise;
    logic        wr_now;
    logic [15:0] wdata;
    logic        soft_q;
    logic        any_rst;
    logic        bcast_q;
    logic [2:0]  rsv_hi_q;
    logic        rsv7_q;
    logic [3:0]  sel_q;
    logic [15:0] gcr_rd;
    logic [15:0] ccr_rd [2];
    logic [15:0] rd_val;
    logic        pass_d;
    logic        sel_ch;

    // Reset images as named constants; a literal cannot be bit-selected
    localparam logic [15:0] GLB_RST = `GCC_GLOBAL_RST;
    localparam logic [15:0] CHN_RST = `GCC_CHAN_RST;

    assign any_rst = rst | soft_q;
    assign rise    = mdc & ~mdc_q;

    // Write fires on the last data bit of a matched write frame
    assign wr_now = (md_q == gcc_pkg::GCC_MD_DATA) && rise && hit_q &&
                    (cnt_q == `GCC_DATA_LAST) && (op_q == `GCC_OP_WR);
    assign wdata  = {sh_q[14:0], mdio_in};

    //------------------------------------------------------------------
    // Clock edge detect
    //------------------------------------------------------------------
    // MDC is slow against sys_clk, so one edge detector is enough
    always_ff @(posedge sys_clk) begin
        if (rst)
            mdc_q <= 1'b0;
        else
            mdc_q <= mdc;
    end

    //------------------------------------------------------------------
    // Management frame engine
    //------------------------------------------------------------------
    // Frame engine survives the soft reset so the bus never hangs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            md_q     <= gcc_pkg::GCC_MD_PRE;
            cnt_q    <= 6'h00;
            sh_q     <= 16'h0000;
            rd_q     <= 16'h0000;
            op_q     <= 2'h0;
            pa0_q    <= 1'b0;
            ra_q     <= 5'h00;
            hit_q    <= 1'b0;
            mdio_out <= 1'b0;
            mdio_oe  <= 1'b0;
        end else if (rise) begin
            unique case (md_q)
                gcc_pkg::GCC_MD_PRE: begin
                    if (mdio_in) begin
                        if (cnt_q != `GCC_PRE_LEN)
                            cnt_q <= cnt_q + 6'h01;
                    end else if (cnt_q == `GCC_PRE_LEN) begin
                        md_q  <= gcc_pkg::GCC_MD_HDR;
                        cnt_q <= 6'h00;
                    end else
                        cnt_q <= 6'h00;
                end
                gcc_pkg::GCC_MD_HDR: begin
                    sh_q <= wdata;
                    if (cnt_q == `GCC_HDR_LAST) begin
                        // Layout: start 1, op 2, phy 5, register 5
                        op_q  <= sh_q[10:9];
                        pa0_q <= sh_q[4];
                        ra_q  <= {sh_q[3:0], mdio_in};
                        hit_q <= sh_q[11] && (sh_q[8:5] == port_addr_hi);
                        md_q  <= gcc_pkg::GCC_MD_TA;
                        cnt_q <= 6'h00;
                    end else
                        cnt_q <= cnt_q + 6'h01;
                end
                gcc_pkg::GCC_MD_TA: begin
                    if (cnt_q == 6'h00) begin
                        rd_q <= rd_val;
                        // Drive the turnaround zero on a read
                        if (hit_q && op_q == `GCC_OP_RD) begin
                            mdio_oe  <= 1'b1;
                            mdio_out <= 1'b0;
                        end
                        cnt_q <= 6'h01;
                    end else begin
                        mdio_out <= rd_q[15];
                        rd_q     <= {rd_q[14:0], 1'b0};
                        md_q     <= gcc_pkg::GCC_MD_DATA;
                        cnt_q    <= 6'h00;
                    end
                end
                gcc_pkg::GCC_MD_DATA: begin
                    sh_q     <= wdata;
                    mdio_out <= rd_q[15];
                    rd_q     <= {rd_q[14:0], 1'b0};
                    if (cnt_q == `GCC_DATA_LAST) begin
                        mdio_oe  <= 1'b0;
                        mdio_out <= 1'b0;
                        md_q     <= gcc_pkg::GCC_MD_PRE;
                        cnt_q    <= 6'h00;
                    end else
                        cnt_q <= cnt_q + 6'h01;
                end
            endcase
        end
    end

    //------------------------------------------------------------------
    // Global control register
    //------------------------------------------------------------------
    // Reset bit is a one-cycle pulse; it also clears the control registers and sync machines
    always_ff @(posedge sys_clk) begin
        if (any_rst) begin
            soft_q   <= 1'b0;
            bcast_q  <= GLB_RST[`GCC_G_BCAST_BIT];
            rsv_hi_q <= GLB_RST[`GCC_G_RSV_HI:`GCC_G_RSV_LO];
            rsv7_q   <= GLB_RST[`GCC_G_RSV7_BIT];
            sel_q    <= GLB_RST[`GCC_G_SEL_HI:0];
        end else if (wr_now && ra_q == `GCC_GLOBAL_ADDR) begin
            soft_q   <= wdata[`GCC_G_RESET_BIT];
            bcast_q  <= wdata[`GCC_G_BCAST_BIT];
            rsv_hi_q <= wdata[`GCC_G_RSV_HI:`GCC_G_RSV_LO];
            rsv7_q   <= wdata[`GCC_G_RSV7_BIT];
            sel_q    <= wdata[`GCC_G_SEL_HI:0];
        end
    end

    // Datapath reset output follows the pulse
    always_ff @(posedge sys_clk) begin
        if (rst)
            datapath_reset <= 1'b1;
        else
            datapath_reset <= soft_q;
    end

    // Reset bit always reads back as zero
    always_comb begin
        gcr_rd = 16'h0000;
        gcr_rd[`GCC_G_BCAST_BIT] = bcast_q;
        gcr_rd[`GCC_G_RSV_HI:`GCC_G_RSV_LO] = rsv_hi_q;
        gcr_rd[`GCC_G_RSV7_BIT] = rsv7_q;
        gcr_rd[`GCC_G_SEL_HI:0] = sel_q;
    end

    //------------------------------------------------------------------
    // Per-channel control and sync
    //------------------------------------------------------------------
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_ch
            logic       pwr_q;
            logic       rxm_q;
            logic       txm_q;
            logic [1:0] hyst_q;
            logic       rxs_q;
            logic       txs_q;
            logic       sel_me;

            // Broadcast lets one write reach both channels
            assign sel_me = bcast_q || (pa0_q == 1'(ch));

            always_ff @(posedge sys_clk) begin
                if (any_rst) begin
                    pwr_q  <= CHN_RST[`GCC_C_PWR_BIT];
                    rxm_q  <= CHN_RST[`GCC_C_RXMODE_BIT];
                    txm_q  <= CHN_RST[`GCC_C_TXMODE_BIT];
                    hyst_q <= CHN_RST[`GCC_C_HYST_HI:`GCC_C_HYST_LO];
                    rxs_q  <= CHN_RST[`GCC_C_RXSEL_BIT];
                    txs_q  <= CHN_RST[`GCC_C_TXSEL_BIT];
                end else if (wr_now && ra_q == `GCC_CHAN_ADDR && sel_me) begin
                    pwr_q  <= wdata[`GCC_C_PWR_BIT];
                    rxm_q  <= wdata[`GCC_C_RXMODE_BIT];
                    txm_q  <= wdata[`GCC_C_TXMODE_BIT];
                    hyst_q <= wdata[`GCC_C_HYST_HI:`GCC_C_HYST_LO];
                    rxs_q  <= wdata[`GCC_C_RXSEL_BIT];
                    txs_q  <= wdata[`GCC_C_TXSEL_BIT];
                end
            end

            // Ratio decode registered so outputs come from flops
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    channel_power_off[ch] <= 1'b0;
                    rx_ratio[2*ch +: 2]   <= gcc_pkg::GCC_RATIO_4;
                    tx_ratio[2*ch +: 2]   <= gcc_pkg::GCC_RATIO_4;
                end else begin
                    channel_power_off[ch] <= pwr_q;
                    rx_ratio[2*ch +: 2]   <= rxm_q ? gcc_pkg::GCC_RATIO_1 :
                        (rxs_q ? gcc_pkg::GCC_RATIO_4 :
                                 gcc_pkg::GCC_RATIO_2);
                    tx_ratio[2*ch +: 2]   <= txm_q ? gcc_pkg::GCC_RATIO_1 :
                        (txs_q ? gcc_pkg::GCC_RATIO_4 :
                                 gcc_pkg::GCC_RATIO_2);
                end
            end

            always_comb begin
                ccr_rd[ch] = 16'h0000;
                ccr_rd[ch][`GCC_C_PWR_BIT]    = pwr_q;
                ccr_rd[ch][`GCC_C_RXMODE_BIT] = rxm_q;
                ccr_rd[ch][`GCC_C_TXMODE_BIT] = txm_q;
                ccr_rd[ch][`GCC_C_HYST_HI:`GCC_C_HYST_LO] = hyst_q;
                ccr_rd[ch][`GCC_C_RXSEL_BIT]  = rxs_q;
                ccr_rd[ch][`GCC_C_TXSEL_BIT]  = txs_q;
            end

            // Powered-off channel holds its sync machine idle
            gcc_sync_fsm u_sync (
                .sys_clk   (sys_clk),
                .rst       (any_rst),
                .hold      (pwr_q),
                .hyst      (gcc_pkg::gcc_hyst_t'(hyst_q)),
                .sym_valid (sym_valid[ch]),
                .sym_err   (sym_err[ch]),
                .sym_comma (sym_comma[ch]),
                .in_sync_q (chan_in_sync[ch])
            );
        end
    endgenerate

    //------------------------------------------------------------------
    // Read data select
    //------------------------------------------------------------------
    // Unmapped registers read as zero
    always_comb begin
        if (ra_q == `GCC_GLOBAL_ADDR)
            rd_val = gcr_rd;
        else if (ra_q == `GCC_CHAN_ADDR)
            rd_val = pa0_q ? ccr_rd[1] : ccr_rd[0];
        else
            rd_val = 16'h0000;
    end

    //------------------------------------------------------------------
    // Pattern pass routing
    //------------------------------------------------------------------
    // Reserved codes drive no pass indication
    assign sel_ch = sel_q[`GCC_SEL_CH_BIT];

    always_comb begin
        pass_d = 1'b0;
        if (sel_q[`GCC_SEL_LS_BIT]) begin
            if (ls_verify_en[sel_ch])
                pass_d = ls_verify_ok[{sel_ch, sel_q[1:0]}];
        end else if (sel_q[1:0] == `GCC_SEL_HS_LANE) begin
            if (hs_verify_en[sel_ch])
                pass_d = hs_verify_ok[sel_ch];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst)
            pattern_pass_pin <= 1'b0;
        else
            pattern_pass_pin <= pass_d;
    end

endmodule

// ==== tb/gcc_mdio_station.sv ====
`timescale 1ns/10ps
module gcc_mdio_station (
    // Clock
    input  wire logic sys_clk,
    // Management wires
    output logic      mdc,
    output logic      mdio_in,
    input  wire logic mdio_out,
    input  wire logic mdio_oe
);
    logic drv_q;
    logic bit_q;
    // Pulled-up line: floats high once everyone lets go
    assign mdio_in = drv_q ? bit_q : (mdio_oe ? mdio_out : 1'b1);
    initial begin
        mdc = 1'b0;
        drv_q = 1'b0;
        bit_q = 1'b1;
    end
    // One bit; clock rests low between frames
    task automatic send_bit(input logic b, output logic smp);
        @(negedge sys_clk);
        bit_q = b;
        repeat (5) @(negedge sys_clk);
        mdc = 1'b1;
        repeat (8) @(negedge sys_clk);
        smp = mdio_in;
        mdc = 1'b0;
    endtask
    // Whole frame, fresh preamble each time, data MSB first
    task automatic frame(input logic rd, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rdat);
        logic [31:0] hdr;
        logic        s;
        hdr = {2'b01, rd ? 2'b10 : 2'b01, pa, ra, 2'b10, wd};
        rdat = 16'h0000;
        drv_q = 1'b1;
        for (int i = 0; i < 32; i++) send_bit(1'b1, s);
        for (int i = 31; i >= 0; i--) begin
            if (rd && i == 17) drv_q = 1'b0; // Hand over at turnaround
            send_bit(hdr[i], s);
            if (i >= 1 && i <= 16) rdat[i-1] = s;
        end
        drv_q = 1'b0;
    endtask
endmodule

// ==== tb/gcc_regs_sva.sv ====
`timescale 1ns/10ps
module gcc_regs_sva (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       mdc,
    // Verification status
    input wire logic [1:0] hs_verify_en,
    input wire logic [1:0] ls_verify_en,
    input wire logic [1:0] hs_verify_ok,
    input wire logic [7:0] ls_verify_ok,
    input wire logic       pattern_pass_pin,
    // Sync and control
    input wire logic [1:0] sym_valid,
    input wire logic [1:0] sym_err,
    input wire logic [1:0] chan_in_sync,
    input wire logic       datapath_reset,
    input wire logic [1:0] channel_power_off,
    input wire logic [3:0] rx_ratio,
    input wire logic [3:0] tx_ratio
);
    // One domain for all checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_reset_state: assert property (disable iff (1'b0)
        rst |=> datapath_reset && channel_power_off == 2'b00)
        else $error("reset state wrong");
    chk_soft_pulse: assert property (
        $rose(datapath_reset) |=> !datapath_reset)
        else $error("soft reset pulse too long");
    chk_soft_clear: assert property (datapath_reset |-> ##3
        (channel_power_off == 2'b00 && rx_ratio == 4'hA && tx_ratio == 4'hA))
        else $error("controls not cleared");
    chk_pass_gate: assert property (pattern_pass_pin |->
        $past(|(hs_verify_en | ls_verify_en)) &&
        $past(|{hs_verify_ok, ls_verify_ok}))
        else $error("pass without cause");
    chk_ctrl_change: assert property (
        $changed({rx_ratio, tx_ratio, channel_power_off}) |-> mdc)
        else $error("control moved without write");
    chk_power_unsync: assert property (
        channel_power_off[1] [*3] |-> !chan_in_sync[1])
        else $error("powered channel in sync");
    chk_ratio_code: assert property (
        rx_ratio[1:0] != 2'b11 && rx_ratio[3:2] != 2'b11 &&
        tx_ratio[1:0] != 2'b11 && tx_ratio[3:2] != 2'b11)
        else $error("illegal ratio code");
    chk_sync_drop: assert property ($fell(chan_in_sync[0]) |->
        $past(sym_valid[0] & sym_err[0]) || channel_power_off[0] ||
        $past(sym_valid[0] & sym_err[0], 2) || $past(datapath_reset) ||
        datapath_reset || $past(channel_power_off[0]))
        else $error("sync lost without error");
    cover property ($fell(chan_in_sync[0]));
    cover property (pattern_pass_pin);
    cover property (channel_power_off[1] [*3]);
endmodule

// ==== tb/gcc_regs_tb.sv ====
`timescale 1ns/10ps
module gcc_regs_tb;
    localparam logic [3:0] PRT = 4'h5; // Arbitrary port address
    logic       sys_clk, rst, mdc, mdio_in, mdio_out, mdio_oe;
    logic [1:0] hs_verify_en, ls_verify_en, hs_verify_ok;
    logic [7:0] ls_verify_ok;
    logic       pattern_pass_pin, datapath_reset;
    logic [1:0] sym_valid, sym_err, sym_comma, chan_in_sync;
    logic [1:0] channel_power_off;
    logic [3:0] rx_ratio, tx_ratio;
    int         errors, cmp_count, cycles, dpr_cnt;
    gcc_regs dut (
        .sys_clk(sys_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .port_addr_hi(PRT),
        .hs_verify_en(hs_verify_en), .ls_verify_en(ls_verify_en),
        .hs_verify_ok(hs_verify_ok), .ls_verify_ok(ls_verify_ok),
        .pattern_pass_pin(pattern_pass_pin), .sym_valid(sym_valid),
        .sym_err(sym_err), .sym_comma(sym_comma),
        .chan_in_sync(chan_in_sync), .datapath_reset(datapath_reset),
        .channel_power_off(channel_power_off), .rx_ratio(rx_ratio),
        .tx_ratio(tx_ratio));
    gcc_mdio_station st (.sys_clk(sys_clk), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Hang guard and soft reset pulse count
    always @(posedge sys_clk) begin
        cycles++;
        if (!rst && datapath_reset) dpr_cnt++;
        if (cycles == 80000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        sym_valid = 2'b00;
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wr(input logic ch, input logic [4:0] ra,
                      input logic [15:0] d);
        logic [15:0] x;
        st.frame(1'b0, {PRT, ch}, ra, d, x);
        idle(4);
    endtask
    task automatic rchk(input logic ch, input logic [4:0] ra,
                        input logic [15:0] exp);
        logic [15:0] d;
        st.frame(1'b1, {PRT, ch}, ra, 16'h0000, d);
        idle(4);
        check(d, exp);
    endtask
    task automatic sym(input int ch, input logic e, input logic c);
        sym_valid[ch] = 1'b1;
        sym_err[ch] = e;
        sym_comma[ch] = c;
        @(negedge sys_clk);
    endtask
    //--------
    // Scenarios
    //--------
    task automatic t_defaults();
        rchk(1'b0, 5'h00, 16'h0600);
        rchk(1'b1, 5'h01, 16'h0300);
        check({8'h00, rx_ratio, tx_ratio}, 16'h00AA);
        wr(1'b0, 5'h05, 16'hFFFF);
        rchk(1'b0, 5'h05, 16'h0000);
    endtask
    task automatic t_channel();
        wr(1'b1, 5'h01, 16'hB400);
        rchk(1'b1, 5'h01, 16'hB400);
        rchk(1'b0, 5'h01, 16'h0300);
        check({8'h00, rx_ratio, tx_ratio}, 16'h0022);
        check({14'h0, channel_power_off}, 16'h0002);
        repeat (3) sym(1, 1'b0, 1'b1);
        idle(3);
        check({15'h0, chan_in_sync[1]}, 16'h0000);
        wr(1'b1, 5'h01, 16'h0300);
        wr(1'b0, 5'h01, 16'h0000);
        check({8'h00, rx_ratio, tx_ratio}, 16'h0099);
    endtask
    task automatic t_broadcast();
        wr(1'b0, 5'h00, 16'h0E00);
        rchk(1'b0, 5'h00, 16'h0E00);
        wr(1'b0, 5'h01, 16'h0100);
        rchk(1'b1, 5'h01, 16'h0100);
        check({8'h00, rx_ratio, tx_ratio}, 16'h005A);
    endtask
    task automatic t_pass();
        int k;
        int e;
        for (int c = 0; c < 16; c++) begin
            k = (c == 0) ? 0 : (c == 8) ? 1 : c[2] ? 2 + 4 * c[3] + c[1:0] : -1;
            e = (k >= 2 ? 2 : 0) + ((k == 1 || k >= 6) ? 1 : 0);
            wr(1'b0, 5'h00, 16'h0600 | c[15:0]);
            {ls_verify_en, hs_verify_en} = 4'hF;
            {ls_verify_ok, hs_verify_ok} = (k < 0) ? 10'h3FF : 10'h001 << k;
            idle(3);
            check({15'h0, pattern_pass_pin}, {15'h0, k >= 0});
            if (k >= 0) begin
                {ls_verify_en, hs_verify_en} = ~(4'h1 << e);
                idle(3);
                check({15'h0, pattern_pass_pin}, 16'h0000);
                {ls_verify_en, hs_verify_en} = 4'hF;
                {ls_verify_ok, hs_verify_ok} = ~(10'h001 << k);
                idle(3);
                check({15'h0, pattern_pass_pin}, 16'h0000);
            end
        end
    endtask
    task automatic t_sync();
        int lim;
        for (int m = 0; m < 4; m++) begin
            lim = (m == 0) ? 4 : m;
            wr(1'b0, 5'h01, {4'h0, m[1:0], 10'h300});
            repeat (3) sym(0, 1'b0, 1'b1);
            repeat (lim - 1) sym(0, 1'b1, 1'b0);
            idle(3);
            check({15'h0, chan_in_sync[0]}, 16'h0001);
            repeat (4) sym(0, 1'b0, 1'b0);
            repeat (lim) sym(0, 1'b1, 1'b0);
            idle(3);
            check({15'h0, chan_in_sync[0]}, 16'h0000);
        end
    endtask
    task automatic t_soft_reset();
        dpr_cnt = 0;
        wr(1'b0, 5'h00, 16'h8E00);
        check(16'(dpr_cnt), 16'h0001);
        rchk(1'b0, 5'h00, 16'h0600);
        rchk(1'b0, 5'h01, 16'h0300);
        check({8'h00, rx_ratio, tx_ratio}, 16'h00AA);
    endtask
    task automatic give_verdict();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        {hs_verify_en, ls_verify_en, hs_verify_ok, ls_verify_ok} = '0;
        {sym_valid, sym_err, sym_comma} = '0;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        t_defaults();
        t_channel();
        t_broadcast();
        t_pass();
        t_sync();
        t_soft_reset();
        give_verdict();
    end
endmodule
bind gcc_regs gcc_regs_sva u_sva (
    .sys_clk(sys_clk), .rst(rst), .mdc(mdc),
    .hs_verify_en(hs_verify_en), .ls_verify_en(ls_verify_en),
    .hs_verify_ok(hs_verify_ok), .ls_verify_ok(ls_verify_ok),
    .pattern_pass_pin(pattern_pass_pin), .sym_valid(sym_valid),
    .sym_err(sym_err), .chan_in_sync(chan_in_sync),
    .datapath_reset(datapath_reset),
    .channel_power_off(channel_power_off), .rx_ratio(rx_ratio),
    .tx_ratio(tx_ratio));
